// ==== core/framer_params.svh ====
// Constants of the serial slave framer: offsets, fields, resets, timing
`ifndef FRAMER_PARAMS_SVH
`define FRAMER_PARAMS_SVH
`define REG_CTRL        8'h00
`define REG_NODE        8'h04
`define REG_BAUD_DIV    8'h08
`define REG_WIN_BASE    8'h0c
`define REG_WIN_COUNT   8'h10
`define REG_STATUS      8'h14
`define CTRL_MODE_LO    0
`define CTRL_MODE_HI    1
`define CTRL_MSW_FIRST  2
`define CTRL_PAR_LO     3
`define CTRL_PAR_HI     4
`define CTRL_ENABLE     5
`define CTRL_RESET      6'h00
`define NODE_RESET      8'h01
`define BAUD_DIV_RESET  16'h196e
`define WIN_BASE_RESET  16'h0000
`define WIN_COUNT_RESET 17'h00000
`define NODE_MIN        8'h01
`define NODE_MAX        8'hf7
`define FN_READ_HOLD    8'h03
`define FN_READ_INPUT   8'h04
`define FN_WRITE_ONE    8'h06
`define FN_WRITE_MANY   8'h10
`define EXC_FLAG        8'h80
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_ADDR    8'h02
`define CHAR_COLON      8'h3a
`define CHAR_CR         8'h0d
`define CHAR_LF         8'h0a
`define DATA_BITS       8
`define RTU_GAP_TENTHS  35
`define ASCII_GAP_MS    1000
`define CLK_HZ          125000000
`define MIN_LEN_RTU     8'h08
`define MIN_LEN_ASCII   8'h07
`define MIN_LEN_TCP     8'h06
`endif

// ==== core/framer_pkg.sv ====
// Types shared by the serial slave framer
package framer_pkg;
  typedef enum logic [1:0] {MODE_ASCII, MODE_RTU, MODE_TCP} mode_type;
  typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} parity_type;
  typedef enum logic [1:0] {ASC_HUNT, ASC_BODY, ASC_LF} asc_state_type;
  typedef enum logic [1:0] {TX_IDLE, TX_PREP, TX_SEND} tx_state_type;
endpackage

// ==== core/half_bit_tick.sv ====
// Divider giving a one-cycle pulse every half bit period
`timescale 1ns/1ps
`default_nettype none
module half_bit_tick (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] div,
  output logic             tick
);
  logic [15:0] count_reg;

  // Divisor of zero behaves as one so the tick never stalls
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= 16'h0000;
    end else if (count_reg + 16'h0001 >= div) begin
      count_reg <= 16'h0000;
    end else begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  assign tick = (count_reg + 16'h0001 >= div);
endmodule // half_bit_tick
`default_nettype wire

// ==== core/crc16_unit.sv ====
// Byte-wise CRC-16 with reflected polynomial, preset to all ones
`timescale 1ns/1ps
`default_nettype none
module crc16_unit (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);
  logic [15:0] crc_reg;
  logic [15:0] crc_next;

  // Eight shift steps per byte, least significant bit first
  always_comb begin
    crc_next = crc_reg ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      crc_next = crc_next[0] ? ((crc_next >> 1) ^ 16'ha001)
                             : (crc_next >> 1);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_reg <= 16'hffff;
    end else if (init) begin
      crc_reg <= 16'hffff;
    end else if (en) begin
      crc_reg <= crc_next;
    end
  end

  assign crc = crc_reg;
endmodule // crc16_unit
`default_nettype wire

// ==== core/serial_slave_framer.sv ====
// Slave-node framer: checks queries, answers address faults itself
//
// Notes on behaviour
// - Invalid address gets error response, no data
// - One bad address in span fails all
// - Two stop bits without parity, else one
// - Master and slave share identical link settings
// - Answer only own node, drop others silently
// - Node zero is no broadcast; dropped
// - TCP-carried requests ignore the node field
// - ASCII body only digits and A-F
// - ASCII opens colon, closes CR LF
// - ASCII gap over one second discards frame
// - RTU packs two nibbles per binary byte
// - RTU silence of 3.5 characters ends frame
// - RTU: node, function, data, 16-bit CRC
// - TCP message: node, function, data, no CRC
// - 32-bit values span two registers
// - Slave never speaks unless queried
// - Drive shared line only while replying
// - Accept functions 03, 04, 06, 10 only
// - Word order picks which half goes first
// - Own node number must be 1 to 247
//
// The APB register port and the register addresses were chosen for this implementation.
`include "framer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_slave_framer #(
  parameter int ASCII_GAP_CYCLES = `ASCII_GAP_MS * (`CLK_HZ / 1000),
  parameter int HDR_BYTES        = 11
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             tx_drive,
  output logic      [1:0]  line_parity,
  output logic             stop_two,
  output logic             req_valid,
  output logic      [7:0]  req_func,
  output logic      [15:0] req_addr,
  output logic      [15:0] req_qty,
  output logic      [31:0] req_wdata32
);
  logic [5:0]  ctrl_reg;
  logic [7:0]  node_reg;
  logic [15:0] baud_div_reg;
  logic [15:0] win_base_reg;
  logic [16:0] win_count_reg;
  logic [7:0]  ok_cnt_reg;
  logic [7:0]  drop_cnt_reg;
  logic [7:0]  exc_cnt_reg;
  logic [31:0] prdata_reg;
  framer_pkg::mode_type      mode;
  framer_pkg::asc_state_type asc_reg;
  framer_pkg::tx_state_type  tx_reg;
  logic [7:0]  hdr_reg [HDR_BYTES];
  logic [7:0]  cnt_reg;
  logic [7:0]  lrc_reg;
  logic        bad_char_reg;
  logic        active_reg;
  logic [3:0]  nib_reg;
  logic        nib_hi_reg;
  logic        eval_pend_reg;
  logic [7:0]  gap_reg;
  logic [31:0] asc_gap_reg;
  logic        push_en;
  logic [7:0]  push_byte;
  logic        frame_end;
  logic        frame_drop;
  logic        hex_ok;
  logic [3:0]  hex_val;
  logic        tick;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;
  logic [7:0]  ex_node_reg;
  logic [7:0]  ex_func_reg;
  logic [7:0]  ex_code_reg;
  logic [3:0]  idx_reg;
  logic [3:0]  tx_len;
  logic [7:0]  tx_data_reg;
  logic        wr_access;
  logic        mapped;
  logic [15:0] hdr_addr;
  logic [15:0] hdr_qty;
  logic [15:0] span_qty;
  logic [16:0] span_last;
  logic        node_ok;
  logic        func_ok;
  logic        addr_ok;
  logic        check_ok;
  logic [4:0]  half_bits;
  logic [7:0]  rtu_gap_lim;

  assign mode = framer_pkg::mode_type'(ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO]);

  // Character framing shared with the line transceiver
  assign line_parity = ctrl_reg[`CTRL_PAR_HI:`CTRL_PAR_LO];
  assign stop_two    = (line_parity == 2'(framer_pkg::PAR_NONE));
  // Start, data, parity and stop bits; eleven either way, in half bits
  assign half_bits   = 5'(2 * (1 + `DATA_BITS + (stop_two ? 2 : 2)));
  assign rtu_gap_lim = 8'((`RTU_GAP_TENTHS * half_bits) / 10);

  // APB decode; zero wait states, so pready is tied high
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign mapped    = (paddr == `REG_CTRL) || (paddr == `REG_NODE) ||
                     (paddr == `REG_BAUD_DIV) || (paddr == `REG_WIN_BASE) ||
                     (paddr == `REG_WIN_COUNT) || (paddr == `REG_STATUS);
  assign pslverr   = psel && penable && !mapped;
  assign prdata    = prdata_reg;

  // Configuration registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg      <= `CTRL_RESET;
      node_reg      <= `NODE_RESET;
      baud_div_reg  <= `BAUD_DIV_RESET;
      win_base_reg  <= `WIN_BASE_RESET;
      win_count_reg <= `WIN_COUNT_RESET;
    end else if (wr_access) begin
      case (paddr)
        `REG_CTRL:      ctrl_reg      <= pwdata[5:0];
        `REG_NODE:      node_reg      <= pwdata[7:0];
        `REG_BAUD_DIV:  baud_div_reg  <= pwdata[15:0];
        `REG_WIN_BASE:  win_base_reg  <= pwdata[15:0];
        `REG_WIN_COUNT: win_count_reg <= pwdata[16:0];
        default:        ;
      endcase
    end
  end

  // Read data captured in setup so it stands through the access phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `REG_CTRL:      prdata_reg <= {26'h0, ctrl_reg};
        `REG_NODE:      prdata_reg <= {24'h0, node_reg};
        `REG_BAUD_DIV:  prdata_reg <= {16'h0, baud_div_reg};
        `REG_WIN_BASE:  prdata_reg <= {16'h0, win_base_reg};
        `REG_WIN_COUNT: prdata_reg <= {15'h0, win_count_reg};
        `REG_STATUS:    prdata_reg <= {7'h0, tx_reg != framer_pkg::TX_IDLE,
                                       exc_cnt_reg, drop_cnt_reg, ok_cnt_reg};
        default:        prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  half_bit_tick u_tick (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .div     (baud_div_reg),
    .tick    (tick)
  );

  // ASCII character classes: only 0-9 and upper-case A-F carry data
  always_comb begin
    hex_ok  = 1'b1;
    hex_val = 4'h0;
    if (rx_data >= 8'h30 && rx_data <= 8'h39) begin
      hex_val = 4'(rx_data - 8'h30);
    end else if (rx_data >= 8'h41 && rx_data <= 8'h46) begin
      hex_val = 4'(rx_data - 8'h37);
    end else begin
      hex_ok = 1'b0;
    end
  end

  // Byte path: binary modes take bytes as they come, ASCII pairs nibbles
  always_comb begin
    push_en   = 1'b0;
    push_byte = rx_data;
    if (ctrl_reg[`CTRL_ENABLE] && rx_valid) begin
      if (mode == framer_pkg::MODE_ASCII) begin
        push_en   = (asc_reg == framer_pkg::ASC_BODY) && hex_ok && nib_hi_reg;
        push_byte = {nib_reg, hex_val};
      end else begin
        push_en = (mode == framer_pkg::MODE_RTU) ||
                  (mode == framer_pkg::MODE_TCP);
      end
    end
  end

  // ASCII framer; a new colon restarts, even mid frame, unless a frame end or drop falls in the same cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      asc_reg      <= framer_pkg::ASC_HUNT;
      nib_reg      <= 4'h0;
      nib_hi_reg   <= 1'b0;
      bad_char_reg <= 1'b0;
    end else if (frame_drop || frame_end) begin
      asc_reg <= framer_pkg::ASC_HUNT;
    end else if (rx_valid && mode == framer_pkg::MODE_ASCII) begin
      if (rx_data == `CHAR_COLON) begin
        asc_reg      <= framer_pkg::ASC_BODY;
        nib_hi_reg   <= 1'b0;
        bad_char_reg <= 1'b0;
      end else if (asc_reg == framer_pkg::ASC_BODY) begin
        if (rx_data == `CHAR_CR) begin
          asc_reg <= framer_pkg::ASC_LF;
        end else if (hex_ok) begin
          nib_reg    <= hex_val;
          nib_hi_reg <= !nib_hi_reg;
        end else begin
          bad_char_reg <= 1'b1;
        end
      end else if (asc_reg == framer_pkg::ASC_LF) begin
        bad_char_reg <= bad_char_reg || (rx_data != `CHAR_LF);
      end
    end
  end

  // End of frame per framing mode; evaluated one cycle after the cause
  assign frame_end = eval_pend_reg;

  // Silence timers restart on every received character
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg     <= 8'h00;
      asc_gap_reg <= 32'h0000_0000;
    end else if (rx_valid) begin
      gap_reg     <= 8'h00;
      asc_gap_reg <= 32'h0000_0000;
    end else begin
      if (tick && gap_reg != 8'hff) begin
        gap_reg <= gap_reg + 8'h01;
      end
      if (asc_reg != framer_pkg::ASC_HUNT) begin
        asc_gap_reg <= asc_gap_reg + 32'h0000_0001;
      end
    end
  end

  // Over one second of ASCII silence discards the frame in progress
  assign frame_drop = (asc_reg != framer_pkg::ASC_HUNT) &&
                      (asc_gap_reg >= 32'(ASCII_GAP_CYCLES));

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eval_pend_reg <= 1'b0;
    end else begin
      case (mode)
        framer_pkg::MODE_RTU:
          eval_pend_reg <= active_reg && !rx_valid && !eval_pend_reg &&
                           tick && (gap_reg + 8'h01 == rtu_gap_lim);
        framer_pkg::MODE_TCP:
          eval_pend_reg <= push_en && rx_last;
        framer_pkg::MODE_ASCII:
          eval_pend_reg <= rx_valid && asc_reg == framer_pkg::ASC_LF;
        default:
          eval_pend_reg <= 1'b0;
      endcase
    end
  end

  crc16_unit u_rx_crc (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .init    (frame_end || !active_reg && !push_en),
    .en      (push_en),
    .data    (push_byte),
    .crc     (rx_crc)
  );

  // Frame capture: header bytes kept, all bytes counted and summed
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg    <= 8'h00;
      lrc_reg    <= 8'h00;
      active_reg <= 1'b0;
    end else if (frame_end || frame_drop ||
                 (rx_valid && rx_data == `CHAR_COLON &&
                  mode == framer_pkg::MODE_ASCII)) begin
      cnt_reg    <= 8'h00;
      lrc_reg    <= 8'h00;
      active_reg <= 1'b0;
    end else if (push_en) begin
      if (cnt_reg != 8'hff) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      lrc_reg    <= lrc_reg + push_byte;
      active_reg <= 1'b1;
    end
  end

  for (genvar g = 0; g < HDR_BYTES; g++) begin : g_hdr
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        hdr_reg[g] <= 8'h00;
      end else if (push_en && cnt_reg == 8'(g)) begin
        hdr_reg[g] <= push_byte;
      end
    end
  end

  // Query checks; outside TCP, node 0 and foreign nodes fall out by the compare
  assign hdr_addr  = {hdr_reg[2], hdr_reg[3]};
  assign hdr_qty   = {hdr_reg[4], hdr_reg[5]};
  assign node_ok   = (mode == framer_pkg::MODE_TCP) ||
                     (node_reg >= `NODE_MIN && node_reg <= `NODE_MAX &&
                      hdr_reg[0] == node_reg);
  assign func_ok   = (hdr_reg[1] == `FN_READ_HOLD) ||
                     (hdr_reg[1] == `FN_READ_INPUT) ||
                     (hdr_reg[1] == `FN_WRITE_ONE) ||
                     (hdr_reg[1] == `FN_WRITE_MANY);
  assign span_qty  = (hdr_reg[1] == `FN_WRITE_ONE) ? 16'h0001 : hdr_qty;
  assign span_last = {1'b0, hdr_addr} + {1'b0, span_qty} - 17'h00001;
  // Whole span must sit in the window, else the query fails entirely
  assign addr_ok   = (span_qty != 16'h0000) && (hdr_addr >= win_base_reg) &&
                     (span_last < {1'b0, win_base_reg} + win_count_reg);
  always_comb begin
    case (mode)
      framer_pkg::MODE_RTU:
        check_ok = (cnt_reg >= `MIN_LEN_RTU) && (rx_crc == 16'h0000);
      framer_pkg::MODE_ASCII:
        check_ok = (cnt_reg >= `MIN_LEN_ASCII) && (lrc_reg == 8'h00) &&
                   !bad_char_reg && !nib_hi_reg;
      framer_pkg::MODE_TCP:
        check_ok = (cnt_reg >= `MIN_LEN_TCP);
      default:
        check_ok = 1'b0;
    endcase
  end

  // Accepted queries go to the register side; 32-bit value per word order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_valid   <= 1'b0;
      req_func    <= 8'h00;
      req_addr    <= 16'h0000;
      req_qty     <= 16'h0000;
      req_wdata32 <= 32'h0000_0000;
    end else begin
      req_valid <= frame_end && check_ok && node_ok && func_ok && addr_ok;
      if (frame_end) begin
        req_func <= hdr_reg[1];
        req_addr <= hdr_addr;
        req_qty  <= span_qty;
        if (hdr_reg[1] == `FN_WRITE_ONE) begin
          req_wdata32 <= {16'h0000, hdr_qty};
        end else if (ctrl_reg[`CTRL_MSW_FIRST]) begin
          req_wdata32 <= {hdr_reg[7], hdr_reg[8], hdr_reg[9], hdr_reg[10]};
        end else begin
          req_wdata32 <= {hdr_reg[9], hdr_reg[10], hdr_reg[7], hdr_reg[8]};
        end
      end
    end
  end

  // Statistics; wrap silently, software reads differences
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ok_cnt_reg   <= 8'h00;
      drop_cnt_reg <= 8'h00;
      exc_cnt_reg  <= 8'h00;
    end else if (frame_end) begin
      if (!check_ok || !node_ok) begin
        drop_cnt_reg <= drop_cnt_reg + 8'h01;
      end else if (func_ok && addr_ok) begin
        ok_cnt_reg <= ok_cnt_reg + 8'h01;
      end else begin
        exc_cnt_reg <= exc_cnt_reg + 8'h01;
      end
    end else if (frame_drop) begin
      drop_cnt_reg <= drop_cnt_reg + 8'h01;
    end
  end

  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
  endfunction

  // Exception reply bytes by framing mode and position
  function automatic logic [7:0] tx_byte(input logic [3:0] i);
    logic [7:0] lrc;
    lrc = 8'h00 - (ex_node_reg + ex_func_reg + ex_code_reg);
    tx_byte = 8'h00;
    if (mode == framer_pkg::MODE_ASCII) begin
      case (i)
        4'h0:    tx_byte = `CHAR_COLON;
        4'h1:    tx_byte = hex_char(ex_node_reg[7:4]);
        4'h2:    tx_byte = hex_char(ex_node_reg[3:0]);
        4'h3:    tx_byte = hex_char(ex_func_reg[7:4]);
        4'h4:    tx_byte = hex_char(ex_func_reg[3:0]);
        4'h5:    tx_byte = hex_char(ex_code_reg[7:4]);
        4'h6:    tx_byte = hex_char(ex_code_reg[3:0]);
        4'h7:    tx_byte = hex_char(lrc[7:4]);
        4'h8:    tx_byte = hex_char(lrc[3:0]);
        4'h9:    tx_byte = `CHAR_CR;
        default: tx_byte = `CHAR_LF;
      endcase
    end else begin
      case (i)
        4'h0:    tx_byte = ex_node_reg;
        4'h1:    tx_byte = ex_func_reg;
        4'h2:    tx_byte = ex_code_reg;
        4'h3:    tx_byte = tx_crc[7:0];
        default: tx_byte = tx_crc[15:8];
      endcase
    end
  endfunction

  assign tx_len = (mode == framer_pkg::MODE_ASCII) ? 4'd11 :
                  (mode == framer_pkg::MODE_RTU)   ? 4'd5  : 4'd3;

  crc16_unit u_tx_crc (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .init    (tx_reg == framer_pkg::TX_IDLE),
    .en      (tx_reg == framer_pkg::TX_PREP),
    .data    (tx_byte(idx_reg)),
    .crc     (tx_crc)
  );

  // Replies only follow a query that passes the node check (any node in TCP); busy drops the new one
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_reg      <= framer_pkg::TX_IDLE;
      idx_reg     <= 4'h0;
      tx_data_reg <= 8'h00;
      ex_node_reg <= 8'h00;
      ex_func_reg <= 8'h00;
      ex_code_reg <= 8'h00;
    end else begin
      case (tx_reg)
        framer_pkg::TX_IDLE: begin
          if (frame_end && check_ok && node_ok &&
              !(func_ok && addr_ok)) begin
            tx_reg      <= framer_pkg::TX_PREP;
            idx_reg     <= 4'h0;
            ex_node_reg <= hdr_reg[0];
            ex_func_reg <= hdr_reg[1] | `EXC_FLAG;
            ex_code_reg <= func_ok ? `EXC_BAD_ADDR : `EXC_BAD_FUNC;
          end
        end
        framer_pkg::TX_PREP: begin
          // Three cycles fold the reply head into the checksum
          if (idx_reg == 4'h2) begin
            tx_reg  <= framer_pkg::TX_SEND;
            idx_reg <= 4'h0;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
        framer_pkg::TX_SEND: begin
          if (tx_ready) begin
            if (idx_reg + 4'h1 == tx_len) begin
              tx_reg <= framer_pkg::TX_IDLE;
            end
            idx_reg <= idx_reg + 4'h1;
          end
        end
        default: tx_reg <= framer_pkg::TX_IDLE;
      endcase
      if (tx_reg == framer_pkg::TX_PREP && idx_reg == 4'h2) begin
        tx_data_reg <= tx_byte(4'h0);
      end else if (tx_reg == framer_pkg::TX_SEND && tx_ready) begin
        tx_data_reg <= tx_byte(idx_reg + 4'h1);
      end
    end
  end

  assign tx_valid = (tx_reg == framer_pkg::TX_SEND);
  assign tx_data  = tx_data_reg;
  // Line driver released as soon as the reply is handed over
  assign tx_drive = (tx_reg != framer_pkg::TX_IDLE);
endmodule // serial_slave_framer
`default_nettype wire

// ==== testbench/framer_sva.sv ====
// Port checker for the serial slave framer
`timescale 1ns/1ps
`default_nettype none
module framer_sva (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_drive,
  input wire logic [1:0]  line_parity,
  input wire logic        stop_two,
  input wire logic        req_valid,
  input wire logic [7:0]  req_func,
  input wire logic [15:0] req_qty
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Line settings, drive window and reply pacing
  a_stop_count: assert property (stop_two == (line_parity == 2'b00))
    else $error("stop bits do not follow parity");
  a_drive_reply: assert property (tx_valid |-> tx_drive)
    else $error("byte offered with driver off");
  a_prep_gap: assert property ($rose(tx_drive) |->
    !tx_valid [*3] ##1 tx_valid) else $error("reply start spacing wrong");
  a_reply_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("reply byte changed before taken");
  // Accepted queries: legal function, non-empty span, never with an error reply
  a_func_legal: assert property (req_valid |->
    req_func inside {8'h03, 8'h04, 8'h06, 8'h10})
    else $error("unsupported function passed on");
  a_no_partial: assert property ($rose(tx_drive) |-> !req_valid)
    else $error("error reply and request together");
  a_qty_nonzero: assert property (req_valid |-> req_qty != 16'h0000)
    else $error("empty span passed on");
  // Bus errors for unmapped places past 0x14, only in access
  a_err_unmapped: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("bus error outside access");
  c_req: cover property (req_valid);
  c_reply: cover property ($rose(tx_drive));
  c_stall: cover property (tx_valid && !tx_ready);
  c_err: cover property (pslverr);
endmodule // framer_sva
bind serial_slave_framer framer_sva i_framer_sva (.*);
`default_nettype wire

// ==== testbench/master_model.sv ====
// Far-side master: sends query bytes, collects reply bytes
`timescale 1ns/1ps
`default_nettype none
module master_model (
  input  wire logic       ref_clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  output logic            tx_ready
);
  logic       slow = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // Sole master speaks first, one byte a cycle
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_data <= b[i];
      rx_last <= (i == b.size() - 1);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~b[b.size() - 1]; // Idle data must not echo last byte
  endtask
  // Slow mode stalls every other cycle
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule // master_model
`default_nettype wire

// ==== testbench/test_serial_slave_framer.sv ====
// Bench for the serial slave framer
`timescale 1ns/1ps
`default_nettype none
module test_serial_slave_framer;
  logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, rx_valid, rx_last, stop_two;
  logic tx_valid, tx_ready, tx_drive, req_valid;
  logic [7:0] paddr = 8'h00, rx_data, tx_data, req_func, q[$], tl[$];
  logic [31:0] pwdata = 32'h0, prdata, rd, req_wdata32;
  logic [15:0] req_addr, req_qty;
  logic [1:0] line_parity;
  int fails = 0, num_checks = 0, nreq = 0;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (req_valid === 1'b1) nreq++;
  serial_slave_framer #(.ASCII_GAP_CYCLES(200), .HDR_BYTES(11))
    i_serial_slave_framer (.*);
  master_model i_master_model (.*);
  task automatic check(input logic [63:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One APB transfer, held until pready at an access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic query(input logic [7:0] n, f, input logic [15:0] a, c,
                       input int nr, ntx);
    int k;
    k = nreq;
    q = '{n, f, a[15:8], a[7:0], c[15:8], c[7:0]};
    if (f == 8'h10) q = {q, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
    q = {q, tl};
    i_master_model.got = {};
    i_master_model.send(q);
    for (int w = 0; w < 200 && i_master_model.got.size() < ntx; w++)
      @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(nreq - k, nr);
    check(i_master_model.got.size(), ntx);
  endtask
  task automatic t_regs();
    logic [7:0]  ad[4] = '{8'h00, 8'h04, 8'h08, 8'h10};
    logic [31:0] ex[4] = '{32'h0, 32'h1, 32'h196e, 32'h0};
    foreach (ad[i]) begin
      apb(1'b0, ad[i], 32'h0);
      check(rd, ex[i]);
    end
    apb(1'b0, 8'h18, 32'h0);
    check({rd, err}, 33'h1);
    for (int p = 2; p >= 0; p--) begin
      apb(1'b1, 8'h00, p << 3);
      check({stop_two, line_parity}, (p == 0) ? 3'h4 : p);
    end
  endtask
  task automatic t_tcp();
    logic [7:0] fn[3] = '{8'h03, 8'h04, 8'h06};
    apb(1'b1, 8'h0c, 32'h10);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h00, 32'h26);
    // Top of window, foreign node field accepted
    foreach (fn[i]) begin
      query(8'h55, fn[i], 16'h0013, 16'h0001, 1, 0);
      check({req_func, req_addr, req_qty}, {fn[i], 32'h00130001});
    end
    query(8'h55, 8'h10, 16'h0010, 16'h0002, 1, 0);
    check(req_wdata32, 32'h11223344);
    apb(1'b1, 8'h00, 32'h22);
    query(8'h55, 8'h10, 16'h0010, 16'h0002, 1, 0);
    check(req_wdata32, 32'h33441122);
  endtask
  task automatic t_exc();
    logic [7:0]  f[4] = '{8'h03, 8'h04, 8'h03, 8'h05};
    logic [15:0] a[4] = '{16'h0013, 16'h000f, 16'h0010, 16'h0010};
    logic [15:0] c[4] = '{16'h0002, 16'h0001, 16'h0000, 16'h0001};
    logic [7:0]  cd[4] = '{8'h02, 8'h02, 8'h02, 8'h01};
    i_master_model.slow = 1'b1;
    foreach (f[i]) begin
      query(8'h01, f[i], a[i], c[i], 0, 3);
      check({i_master_model.got[0], i_master_model.got[1],
             i_master_model.got[2]}, {8'h01, f[i] | 8'h80, cd[i]});
      check(tx_drive, 1'b0);
    end
    i_master_model.slow = 1'b0;
  endtask
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  task automatic ascii(input logic [7:0] n, bad, input int nr);
    logic [7:0] b[$];
    logic [7:0] s;
    int k;
    b = '{n, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01};
    s = 8'h00;
    k = nreq;
    foreach (b[i]) s += b[i];
    b.push_back((8'h00 - s) ^ bad); // LRC, optionally spoiled
    q = '{8'h3a};
    foreach (b[i]) q = {q, hx(b[i][7:4]), hx(b[i][3:0])};
    q = {q, 8'h0d, 8'h0a};
    i_master_model.send(q);
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    check(nreq - k, nr);
  endtask
  task automatic t_ascii();
    apb(1'b1, 8'h00, 32'h20);
    ascii(8'h01, 8'h00, 1);
    ascii(8'h02, 8'h00, 0);
    ascii(8'h00, 8'h00, 0);
    ascii(8'h01, 8'h01, 0);
  endtask
  task automatic t_rtu();
    apb(1'b1, 8'h08, 32'h1);
    apb(1'b1, 8'h00, 32'h21);
    tl = {8'h84, 8'h0a};
    query(8'h01, 8'h03, 16'h0000, 16'h0001, 0, 5);
    check({i_master_model.got[3], i_master_model.got[4]}, 16'hc0f1);
  endtask
  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_tcp();
    t_exc();
    t_ascii();
    t_rtu();
    summarize();
  end
  // Whole run needs a few hundred cycles
  initial begin
    #100000;
    fails++;
    summarize();
  end
endmodule // test_serial_slave_framer
`default_nettype wire
